// file: flash_bus_cycle.sv
/*
 * One asynchronous flash bus cycle: a write strobe or a read strobe
 * with fixed setup, strobe and hold phases.
 * Address and data are registered at start_i, so the requester need not hold them until done_o.
 */
`timescale 1ns/100ps
`default_nettype none

module flash_bus_cycle (
  input wire logic clk_sys_i, // System clock.
  input wire logic arst_n_i, // Asynchronous reset, active low.
  input wire logic start_i, // One-cycle request.
  input wire logic write_i, // High for a write cycle.
  input wire logic [23:0] addr_i, // Word address.
  input wire logic [15:0] wdata_i, // Write data.
  input wire logic [15:0] dq_in_i, // Synchronised data pins.
  output logic [23:0] addr_o, // Address pins.
  output logic [15:0] dq_o, // Data pins driven.
  output logic dq_oe_n_o, // Data drive enable, low while driving.
  output logic ce_n_o, // Chip enable, active low.
  output logic we_n_o, // Write strobe, active low.
  output logic oe_n_o, // Read strobe, active low.
  output logic [15:0] rdata_o, // Captured read word.
  output logic done_o // One-cycle completion pulse.
);

  typedef enum logic [1:0] {
    CYC_IDLE = 2'b00,
    CYC_SETUP = 2'b01,
    CYC_STROBE = 2'b10,
    CYC_HOLD = 2'b11
  } cyc_state_type;

  typedef struct packed {
    cyc_state_type st;
    logic [3:0] cnt;
    logic wr;
    logic [23:0] addr;
    logic [15:0] dq;
    logic dq_oe_n;
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic [15:0] rdata;
    logic done;
  } cyc_type;

  cyc_type cyc_r;
  cyc_type cyc_nxt;

  always_comb begin
    cyc_nxt = cyc_r;
    cyc_nxt.done = 1'b0;
    unique case (cyc_r.st)
      CYC_IDLE: begin
        if (start_i) begin
          cyc_nxt.st = CYC_SETUP;
          cyc_nxt.cnt = flash_erase_pkg::PHASE_CYC;
          cyc_nxt.wr = write_i;
          cyc_nxt.addr = addr_i;
          cyc_nxt.dq = wdata_i;
          cyc_nxt.dq_oe_n = ~write_i;
          cyc_nxt.ce_n = 1'b0;
        end
      end
      CYC_SETUP: begin
        cyc_nxt.cnt = cyc_r.cnt - 4'h1;
        if (cyc_r.cnt == 4'h1) begin
          cyc_nxt.st = CYC_STROBE;
          cyc_nxt.cnt = flash_erase_pkg::PHASE_CYC;
          cyc_nxt.we_n = ~cyc_r.wr;
          cyc_nxt.oe_n = cyc_r.wr;
        end
      end
      CYC_STROBE: begin
        cyc_nxt.cnt = cyc_r.cnt - 4'h1;
        if (cyc_r.cnt == 4'h1) begin
          cyc_nxt.st = CYC_HOLD;
          cyc_nxt.cnt = flash_erase_pkg::PHASE_CYC;
          cyc_nxt.we_n = 1'b1;
          cyc_nxt.oe_n = 1'b1;
        end
      end
      CYC_HOLD: begin
        cyc_nxt.cnt = cyc_r.cnt - 4'h1;
        if (cyc_r.cnt == 4'h1) begin
          cyc_nxt.st = CYC_IDLE;
          cyc_nxt.ce_n = 1'b1;
          cyc_nxt.dq_oe_n = 1'b1;
          cyc_nxt.done = 1'b1;
          // The pins reach dq_in_i two flops late, so this word is what
          // they showed while the read strobe was still low.
          cyc_nxt.rdata = dq_in_i;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cyc_r <= '{st: CYC_IDLE, cnt: 4'h0, wr: 1'b0, addr: 24'h000000,
                 dq: 16'h0000, dq_oe_n: 1'b1, ce_n: 1'b1, we_n: 1'b1,
                 oe_n: 1'b1, rdata: 16'h0000, done: 1'b0};
    end else begin
      cyc_r <= cyc_nxt;
    end
  end

  assign addr_o = cyc_r.addr;
  assign dq_o = cyc_r.dq;
  assign dq_oe_n_o = cyc_r.dq_oe_n;
  assign ce_n_o = cyc_r.ce_n;
  assign we_n_o = cyc_r.we_n;
  assign oe_n_o = cyc_r.oe_n;
  assign rdata_o = cyc_r.rdata;
  assign done_o = cyc_r.done;

endmodule

`default_nettype wire

// file: flash_erase_ctrl.sv
/*
 * Host-side erase controller for a parallel NOR flash. Software orders
 * sector or chip erases over AXI4-Lite; the block writes the six-cycle
 * sequences, adds further sectors inside the selection window, sends
 * suspend during sector erases, polls status until done and can pulse the flash reset.
 * Assumes a word-wide flash whose status reads follow the toggle scheme.
 */
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
`default_nettype none

module flash_erase_ctrl (
  input wire logic clk_sys_i, // System clock, 10 MHz.
  input wire logic arst_n_i, // Asynchronous reset, active low.
  input wire logic [7:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [7:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  output logic [23:0] flash_addr_o, // Flash word address.
  input wire logic [15:0] flash_dq_i, // Flash data pins in.
  output logic [15:0] flash_dq_o, // Flash data pins out.
  output logic flash_dq_oe_n_o, // Data drive enable, low while driving.
  output logic flash_ce_n_o, // Flash chip enable, active low.
  output logic flash_we_n_o, // Flash write strobe, active low.
  output logic flash_oe_n_o, // Flash read strobe, active low.
  output logic flash_reset_n_o // Flash hardware reset, active low.
);

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_SEQ = 4'b0001,
    ST_WIN = 4'b0010,
    ST_POLL_A = 4'b0011,
    ST_POLL_B = 4'b0100,
    ST_SUSP = 4'b0101,
    ST_RST = 4'b0110,
    ST_VERIFY = 4'b0111
  } ctl_state_type;

  typedef struct packed {
    ctl_state_type st;
    logic [2:0] step;
    logic chip;
    logic [23:0] addr;
    logic [15:0] win_cnt;
    logic win_open;
    logic busy;
    logic done;
    logic refused;
    logic suspended;
    logic fail;
    logic timer_flag;
    logic [15:0] last_read;
    logic [15:0] prev_read;
    logic go_pend;
    logic extra_pend;
    logic susp_pend;
    logic rst_pend;
    logic start;
    logic wr;
    logic [23:0] cyc_addr;
    logic [15:0] cyc_data;
    logic flash_rst_n;
    logic [3:0] rst_cnt;
    logic awready;
    logic wready;
    logic bvalid;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] bresp;
  } ctl_type;

  localparam logic [15:0] WIN_COUNT = 16'(flash_erase_pkg::WIN_CYC);
  // Extra selects stop this many cycles before the count ends, because the
  // count starts late and a new write strobes several cycles after start.
  localparam logic [15:0] WIN_MARGIN = 16'(4 * flash_erase_pkg::PHASE_CYC);

  ctl_type s_r;
  ctl_type s_nxt;
  logic [15:0] dq_meta_r;
  logic [15:0] dq_sync_r;
  logic [15:0] cyc_rdata;
  logic cyc_done;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dq_meta_r <= 16'h0000;
      dq_sync_r <= 16'h0000;
    end else begin
      dq_meta_r <= flash_dq_i;
      dq_sync_r <= dq_meta_r;
    end
  end

  flash_bus_cycle u_cycle (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .start_i(s_r.start),
    .write_i(s_r.wr),
    .addr_i(s_r.cyc_addr),
    .wdata_i(s_r.cyc_data),
    .dq_in_i(dq_sync_r),
    .addr_o(flash_addr_o),
    .dq_o(flash_dq_o),
    .dq_oe_n_o(flash_dq_oe_n_o),
    .ce_n_o(flash_ce_n_o),
    .we_n_o(flash_we_n_o),
    .oe_n_o(flash_oe_n_o),
    .rdata_o(cyc_rdata),
    .done_o(cyc_done)
  );

  // Fixed unlock and setup steps 0..4; step 5 is the erase command.
  function automatic logic [39:0] seq_word(input logic [2:0] step);
    logic [39:0] w;
    w = 40'h0;
    unique case (step)
      3'h0: w = {flash_erase_pkg::UNLOCK_ADDR_A, flash_erase_pkg::UNLOCK_DATA_A};
      3'h1: w = {flash_erase_pkg::UNLOCK_ADDR_B, flash_erase_pkg::UNLOCK_DATA_B};
      3'h2: w = {flash_erase_pkg::UNLOCK_ADDR_A, flash_erase_pkg::SETUP_DATA};
      3'h3: w = {flash_erase_pkg::UNLOCK_ADDR_A, flash_erase_pkg::UNLOCK_DATA_A};
      default: w = {flash_erase_pkg::UNLOCK_ADDR_B, flash_erase_pkg::UNLOCK_DATA_B};
    endcase
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [15:0] diff;
    diff = 16'h0000;
    s_nxt = s_r;
    s_nxt.start = 1'b0;
    s_nxt.awready = 1'b0;
    s_nxt.wready = 1'b0;
    s_nxt.arready = 1'b0;
    // Register write: address and data taken together once both arrive.
    if (s_axi_awvalid && s_axi_wvalid && !s_r.bvalid && !s_r.awready) begin
      s_nxt.awready = 1'b1;
      s_nxt.wready = 1'b1;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = flash_erase_pkg::RESP_OKAY;
      if (s_axi_awaddr == flash_erase_pkg::CTRL_OFS && s_axi_wstrb[0]) begin
        s_nxt.go_pend = s_r.go_pend | s_axi_wdata[flash_erase_pkg::CTRL_GO_BIT];
        s_nxt.extra_pend = s_r.extra_pend
                         | s_axi_wdata[flash_erase_pkg::CTRL_EXTRA_BIT];
        s_nxt.susp_pend = s_r.susp_pend
                        | s_axi_wdata[flash_erase_pkg::CTRL_SUSP_BIT];
        s_nxt.rst_pend = s_r.rst_pend | s_axi_wdata[flash_erase_pkg::CTRL_RST_BIT];
        if (s_axi_wdata[flash_erase_pkg::CTRL_GO_BIT] && !s_r.busy) begin
          s_nxt.chip = s_axi_wdata[flash_erase_pkg::CTRL_CHIP_BIT];
        end
      end else if (s_axi_awaddr == flash_erase_pkg::ADDR_OFS) begin
        s_nxt.addr = s_axi_wdata[23:0];
      end else begin
        s_nxt.bresp = flash_erase_pkg::RESP_SLVERR;
      end
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_axi_arvalid && !s_r.rvalid && !s_r.arready) begin
      s_nxt.arready = 1'b1;
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = flash_erase_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        flash_erase_pkg::CTRL_OFS: s_nxt.rdata = {31'h0, s_r.chip};
        flash_erase_pkg::ADDR_OFS: s_nxt.rdata = {8'h00, s_r.addr};
        flash_erase_pkg::STATUS_OFS: s_nxt.rdata = {25'h0, s_r.timer_flag,
          s_r.fail, s_r.suspended, s_r.refused, s_r.win_open, s_r.done,
          s_r.busy};
        flash_erase_pkg::RDATA_OFS: s_nxt.rdata = {16'h0, s_r.last_read};
        default: begin
          s_nxt.rdata = 32'h0;
          s_nxt.rresp = flash_erase_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_r.win_open && s_r.win_cnt != 16'h0) begin
      s_nxt.win_cnt = s_r.win_cnt - 16'h1;
    end
    unique case (s_r.st)
      ST_IDLE: begin
        s_nxt.extra_pend = 1'b0;
        s_nxt.susp_pend = 1'b0;
        if (s_r.rst_pend) begin
          s_nxt.rst_pend = 1'b0;
          s_nxt.st = ST_RST;
          s_nxt.flash_rst_n = 1'b0;
          s_nxt.rst_cnt = 4'hF;
        end else if (s_r.go_pend) begin
          s_nxt.go_pend = 1'b0;
          s_nxt.busy = 1'b1;
          s_nxt.done = 1'b0;
          s_nxt.fail = 1'b0;
          s_nxt.refused = 1'b0;
          s_nxt.suspended = 1'b0;
          s_nxt.step = 3'h0;
          s_nxt.st = ST_SEQ;
          s_nxt.start = 1'b1;
          s_nxt.wr = 1'b1;
          {s_nxt.cyc_addr, s_nxt.cyc_data} = seq_word(3'h0);
        end
      end
      ST_SEQ: begin
        if (cyc_done) begin
          if (s_r.step == 3'h5) begin
            // Window count starts once the sixth strobe has risen.
            s_nxt.win_open = ~s_r.chip;
            s_nxt.win_cnt = WIN_COUNT;
            s_nxt.st = s_r.chip ? ST_POLL_A : ST_WIN;
          end else begin
            s_nxt.step = s_r.step + 3'h1;
            s_nxt.start = 1'b1;
            if (s_r.step == 3'h4 && s_r.chip) begin
              s_nxt.cyc_addr = flash_erase_pkg::UNLOCK_ADDR_A;
              s_nxt.cyc_data = flash_erase_pkg::CHIP_ERASE_DATA;
            end else if (s_r.step == 3'h4) begin
              s_nxt.cyc_addr = s_r.addr;
              s_nxt.cyc_data = flash_erase_pkg::SECTOR_ERASE_DATA;
            end else begin
              {s_nxt.cyc_addr, s_nxt.cyc_data} = seq_word(s_r.step + 3'h1);
            end
          end
        end
      end
      ST_WIN: begin
        // Only sector selects and suspend are ever written here.
        if (s_r.susp_pend) begin
          s_nxt.susp_pend = 1'b0;
          s_nxt.win_open = 1'b0;
          s_nxt.start = 1'b1;
          s_nxt.cyc_addr = s_r.addr;
          s_nxt.cyc_data = flash_erase_pkg::SUSPEND_DATA;
          s_nxt.st = ST_SUSP;
        end else if (s_r.extra_pend && s_r.win_cnt > WIN_MARGIN) begin
          s_nxt.extra_pend = 1'b0;
          s_nxt.start = 1'b1;
          s_nxt.cyc_addr = s_r.addr;
          s_nxt.cyc_data = flash_erase_pkg::SECTOR_ERASE_DATA;
          s_nxt.st = ST_SEQ;
          s_nxt.step = 3'h5;
        end else if (s_r.win_cnt == 16'h0) begin
          // A late select is refused rather than hoped for.
          s_nxt.refused = s_r.extra_pend;
          s_nxt.extra_pend = 1'b0;
          s_nxt.win_open = 1'b0;
          s_nxt.st = ST_POLL_A;
        end
      end
      ST_POLL_A, ST_POLL_B: begin
        if (s_r.extra_pend) begin
          s_nxt.extra_pend = 1'b0;
          s_nxt.refused = 1'b1;
        end
        if (s_r.rst_pend) begin
          s_nxt.rst_pend = 1'b0;
          s_nxt.busy = 1'b0;
          s_nxt.fail = 1'b1;
          s_nxt.st = ST_RST;
          s_nxt.flash_rst_n = 1'b0;
          s_nxt.rst_cnt = 4'hF;
        end else if (s_r.susp_pend && !s_r.chip && s_r.st == ST_POLL_A) begin
          s_nxt.susp_pend = 1'b0;
          s_nxt.start = 1'b1;
          s_nxt.wr = 1'b1;
          s_nxt.cyc_addr = s_r.addr;
          s_nxt.cyc_data = flash_erase_pkg::SUSPEND_DATA;
          s_nxt.st = ST_SUSP;
        end else if (s_r.st == ST_POLL_A) begin
          s_nxt.susp_pend = 1'b0;
          s_nxt.start = 1'b1;
          s_nxt.wr = 1'b0;
          s_nxt.cyc_addr = s_r.addr;
          s_nxt.st = ST_POLL_B;
        end else if (cyc_done) begin
          // Status reads in the erasing sector; toggling means busy.
          diff = cyc_rdata ^ s_r.prev_read;
          s_nxt.prev_read = cyc_rdata;
          s_nxt.last_read = cyc_rdata;
          s_nxt.timer_flag = cyc_rdata[flash_erase_pkg::TIMER_BIT];
          if (!diff[flash_erase_pkg::TOGGLE_BIT]
              && !diff[flash_erase_pkg::STOGGLE_BIT]
              && cyc_rdata == flash_erase_pkg::ERASED_WORD) begin
            s_nxt.st = ST_VERIFY;
          end else begin
            s_nxt.st = ST_POLL_A;
          end
        end
      end
      ST_VERIFY: begin
        // An all-ones read with both toggle bits unchanged from the last read means array data is back.
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
        s_nxt.st = ST_IDLE;
      end
      ST_SUSP: begin
        if (cyc_done) begin
          s_nxt.suspended = 1'b1;
          s_nxt.busy = 1'b0;
          s_nxt.st = ST_IDLE;
        end
      end
      ST_RST: begin
        s_nxt.rst_cnt = s_r.rst_cnt - 4'h1;
        s_nxt.win_open = 1'b0;
        if (s_r.rst_cnt == 4'h0) begin
          s_nxt.flash_rst_n = 1'b1;
          s_nxt.busy = 1'b0;
          s_nxt.st = ST_IDLE;
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
      s_r.flash_rst_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready = s_r.awready;
  assign s_axi_wready = s_r.wready;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = s_r.arready;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  assign flash_reset_n_o = s_r.flash_rst_n;

endmodule

`default_nettype wire

// file: flash_erase_ctrl_chk.sv
/* Port checker for flash_erase_ctrl: AXI answers and flash strobes.
   Assumes one clock domain; bound to every controller instance. */
`timescale 1ns/100ps
`default_nettype none
module flash_erase_ctrl_chk (
  input wire logic clk_sys_i, // Clock.
  input wire logic arst_n_i, // Reset, active low.
  input wire logic s_axi_awready, // Address taken.
  input wire logic s_axi_wready, // Data taken.
  input wire logic s_axi_bvalid, // Write answer.
  input wire logic s_axi_bready, // Answer taken.
  input wire logic s_axi_rvalid, // Read answer.
  input wire logic s_axi_rready, // Read taken.
  input wire logic [23:0] flash_addr_o, // Flash address.
  input wire logic [15:0] flash_dq_o, // Flash data out.
  input wire logic flash_dq_oe_n_o, // Data drive, low active.
  input wire logic flash_ce_n_o, // Chip enable.
  input wire logic flash_we_n_o, // Write strobe.
  input wire logic flash_oe_n_o, // Read strobe.
  input wire logic flash_reset_n_o // Flash reset.
);
  logic [4:0] rst_cnt_r;
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_cnt_r <= 5'h00;
    end else if (flash_reset_n_o) begin
      rst_cnt_r <= 5'h00;
    end else begin
      rst_cnt_r <= rst_cnt_r + 5'h01;
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  ////////////////////////////////////////////////////////////////////////
  sequence s_strobe;
    !flash_we_n_o ##1 flash_we_n_o;
  endsequence
  property p_wr_ans;
    s_axi_awready |-> s_axi_wready && s_axi_bvalid;
  endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid;
  endproperty
  property p_strobe;
    $fell(flash_we_n_o) |=> s_strobe;
  endproperty
  property p_setup;
    $fell(flash_we_n_o) |-> !$past(flash_ce_n_o, 2);
  endproperty
  property p_hold;
    !flash_we_n_o |=> $stable(flash_addr_o) && $stable(flash_dq_o);
  endproperty
  property p_drive;
    !flash_we_n_o |-> !flash_dq_oe_n_o && !flash_ce_n_o;
  endproperty
  property p_excl;
    !flash_oe_n_o |-> flash_we_n_o && flash_dq_oe_n_o;
  endproperty
  property p_rst;
    $rose(flash_reset_n_o) |-> rst_cnt_r == 5'h10;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer split");
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
  a_r_hold: assert property (p_r_hold) else $error("rvalid dropped");
  a_strobe: assert property (p_strobe) else $error("strobe length");
  a_setup: assert property (p_setup) else $error("setup too short");
  a_hold: assert property (p_hold) else $error("address moved");
  a_drive: assert property (p_drive) else $error("write undriven");
  a_excl: assert property (p_excl) else $error("read clash");
  a_rst: assert property (p_rst) else $error("reset length");
endmodule
bind flash_erase_ctrl flash_erase_ctrl_chk i_chk (.clk_sys_i, .arst_n_i,
  .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_rvalid, .s_axi_rready, .flash_addr_o, .flash_dq_o,
  .flash_dq_oe_n_o, .flash_ce_n_o, .flash_we_n_o, .flash_oe_n_o,
  .flash_reset_n_o);
`default_nettype wire

// file: flash_erase_pkg.sv
/*
 * Shared constants for the NOR flash erase controller: register map,
 * command words, unlock addresses and timing counts.
 * Assumes a 10 MHz system clock and a 16-bit word-wide flash bus.
 */
package flash_erase_pkg;

  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned WIN_US = 50;
  localparam int unsigned WIN_CYC = (WIN_US * (CLK_HZ / 1_000_000));
  // Strobe phase lengths in system cycles (100 ns each).
  localparam logic [3:0] PHASE_CYC = 4'h2;

  localparam logic [23:0] UNLOCK_ADDR_A = 24'h000555;
  localparam logic [23:0] UNLOCK_ADDR_B = 24'h0002AA;
  localparam logic [15:0] UNLOCK_DATA_A = 16'h00AA;
  localparam logic [15:0] UNLOCK_DATA_B = 16'h0055;
  localparam logic [15:0] SETUP_DATA = 16'h0080;
  localparam logic [15:0] SECTOR_ERASE_DATA = 16'h0030;
  localparam logic [15:0] CHIP_ERASE_DATA = 16'h0010;
  localparam logic [15:0] SUSPEND_DATA = 16'h00B0;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;

  // Register byte offsets.
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] ADDR_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] RDATA_OFS = 8'h0C;

  // Control register field positions.
  localparam int unsigned CTRL_GO_BIT = 0;
  localparam int unsigned CTRL_CHIP_BIT = 1;
  localparam int unsigned CTRL_EXTRA_BIT = 2;
  localparam int unsigned CTRL_SUSP_BIT = 3;
  localparam int unsigned CTRL_RST_BIT = 4;

  // Flash status bit positions.
  localparam int unsigned POLL_BIT = 7;
  localparam int unsigned TOGGLE_BIT = 6;
  localparam int unsigned TIMER_BIT = 3;
  localparam int unsigned STOGGLE_BIT = 2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: flash_model.sv
/* Behavioural word-wide NOR flash: erase command decoder and status.
   Assumes writes latch at the rising write strobe with chip enable low. */
`timescale 1ns/100ps
`default_nettype none
module flash_model #(
  parameter int ERASE_NS = 100000
) (
  input wire logic [23:0] addr_i, // Word address.
  input wire logic [15:0] dq_i, // Written data.
  input wire logic ce_n_i, // Chip enable.
  input wire logic we_n_i, // Write strobe.
  input wire logic oe_n_i, // Read strobe.
  input wire logic reset_n_i, // Hardware reset.
  output logic [15:0] dq_o // Read data.
);
  int step = 0;
  bit win, run, chip, susp, tog;
  realtime t0;
  logic [15:0] st = 16'hFFFF;
  // Released pins show the inverse so stale data never reads as valid.
  assign dq_o = (oe_n_i || ce_n_i) ? ~st : st;
  task automatic tick();
    if (win && $realtime - t0 >= 50000) begin
      win = 0;
      t0 = $realtime;
    end
    if (run && !win && !susp && $realtime - t0 >= ERASE_NS) run = 0;
  endtask
  always @(posedge we_n_i) if (!ce_n_i && reset_n_i) begin
    tick();
    if (run && chip) begin
    end else if (run && win) begin
      if (dq_i == 16'h0030) t0 = $realtime;
      else if (dq_i == 16'h00B0) {win, susp} = 2'h1;
      else run = 0;
    end else if (run) begin
      susp |= (dq_i == 16'h00B0);
    end else if (step == 5 && dq_i == 16'h0030) begin
      {run, win, chip, susp, step} = {4'hC, 32'h0};
      t0 = $realtime;
    end else if (step == 5 && {addr_i, dq_i} == 40'h0005550010) begin
      {run, win, chip, susp, step} = {4'hA, 32'h0};
      t0 = $realtime;
    end else if ({addr_i, dq_i} == (step inside {0, 3} ? 40'h00055500AA :
        step inside {1, 4} ? 40'h0002AA0055 : 40'h0005550080)) begin
      step++;
    end else step = 0;
  end
  always @(negedge oe_n_i) begin
    tick();
    tog = ~tog;
    if (!run) st = 16'hFFFF;
    else st = {9'h000, tog & ~susp, 2'h0, ~win, tog, 2'h0};
  end
  always @(negedge reset_n_i) {run, win, susp, step} = 0;
endmodule
`default_nettype wire

// file: tb_flash_erase_ctrl.sv
/* Self-checking bench for flash_erase_ctrl with a flash model.
   Assumes the controller answers AXI4-Lite as its hand-over says. */
`timescale 1ns/100ps
`default_nettype none
module tb_flash_erase_ctrl;
  logic clk_sys_i = 1'h0, arst_n_i = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rs;
  logic [23:0] faddr, sa, sb;
  logic [15:0] fdq_o, fdq_i, mdq;
  logic dq_oe_n, ce_n, we_n, oe_n, frst_n;
  int err_count = 0, check_count = 0, cyc = 0, seed = 82, n;
  logic [39:0] wq[$];
  always #50 clk_sys_i = ~clk_sys_i;
  assign fdq_i = dq_oe_n ? mdq : fdq_o;
  flash_erase_ctrl i_dut (.clk_sys_i, .arst_n_i, .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_rdata(rdata),
    .s_axi_arready(arready), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .flash_addr_o(faddr), .flash_dq_i(fdq_i),
    .flash_dq_o(fdq_o), .flash_dq_oe_n_o(dq_oe_n), .flash_ce_n_o(ce_n),
    .flash_we_n_o(we_n), .flash_oe_n_o(oe_n), .flash_reset_n_o(frst_n));
  flash_model #(.ERASE_NS(100000)) i_flash (.addr_i(faddr), .dq_i(fdq_o),
    .ce_n_i(ce_n), .we_n_i(we_n), .oe_n_i(oe_n), .reset_n_i(frst_n),
    .dq_o(mdq));
  always @(posedge we_n) if (ce_n === 1'h0) wq.push_back({faddr, fdq_o});
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // Ready and valid are read at the falling edge, which is what the next
  // rising edge samples, so the bench never races the controller.
  // A random first level of bready and rready makes some answers wait.
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb, tr;
    @(posedge clk_sys_i);
    {awaddr, wdata, awvalid, wvalid} <= {a, d, 2'h3};
    bready <= 1'($random(seed));
    do begin
      @(negedge clk_sys_i);
      {ta, tw, tb, tr, rs} = {awready, wready, bvalid, bready, bresp};
      @(posedge clk_sys_i);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
      if (tb && !tr) bready <= 1'h1;
    end while (!(tb === 1'h1 && tr === 1'h1));
    bready <= 1'h0;
  endtask
  task automatic axr(input logic [7:0] a);
    logic ta, tv, tr;
    @(posedge clk_sys_i);
    {araddr, arvalid} <= {a, 1'h1};
    rready <= 1'($random(seed));
    do begin
      @(negedge clk_sys_i);
      {ta, tv, tr, rd, rs} = {arready, rvalid, rready, rdata, rresp};
      @(posedge clk_sys_i);
      if (ta) arvalid <= 1'h0;
      if (tv && !tr) rready <= 1'h1;
    end while (!(tv === 1'h1 && tr === 1'h1));
    rready <= 1'h0;
  endtask
  task automatic st_wait(input int b, input logic v);
    n = 0;
    do begin
      axr(8'h08);
      n++;
    end while (rd[b] !== v && n < 3000);
    chk(40'(rd[b]), 40'(v));
  endtask
  function automatic logic [39:0] exp_w(input int i);
    return i inside {0, 3} ? 40'h00055500AA :
      i inside {1, 4} ? 40'h0002AA0055 : 40'h0005550080;
  endfunction
  task automatic erase(input logic [31:0] c, input logic [39:0] last);
    wq.delete();
    axw(8'h04, {8'h00, sa});
    axw(8'h00, c);
    n = 0;
    while (wq.size() < 6 && n < 300) begin
      @(negedge clk_sys_i);
      n++;
    end
    for (int i = 0; i < 5; i++) chk(wq[i], exp_w(i));
    chk(wq[5], last);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk_sys_i);
    arst_n_i <= 1'h1;
    axr(8'h08);
    chk({rs, rd, frst_n}, 40'h1);
    axw(8'h10, 32'h1);
    chk(40'(rs), 40'h2);
    axr(8'h14);
    chk({rs, rd}, 40'h200000000);
    for (int k = 0; k < 3; k++) begin
      {sa, sb} = 48'({$random(seed), $random(seed)});
      erase(32'h1, {sa, 16'h0030});
      st_wait(2, 1'h1);
      if (k == 1) axw(8'h04, {8'h00, sb});
      if (k == 1) axw(8'h00, 32'h4);
      if (k == 2) st_wait(2, 1'h0);
      if (k == 2) axw(8'h00, 32'h4);
      if (k == 2) break;
      st_wait(1, 1'h1);
      chk(40'(wq.size()), 40'(6 + k));
      if (k == 1) chk(wq[6], {sb, 16'h0030});
      axr(8'h08);
      chk(40'(rd[6]), 40'h1);
      axr(8'h0C);
      chk(40'(rd[15:0]), 40'hFFFF);
    end
    axr(8'h08);
    chk({rd[3], rd[0], 6'(wq.size())}, 40'hC6);
    axw(8'h00, 32'h10);
    n = 0;
    while (frst_n !== 1'h0 && n < 100) @(negedge clk_sys_i) n++;
    n = 0;
    while (frst_n === 1'h0 && n < 100) @(negedge clk_sys_i) n++;
    chk(40'(n), 40'h10);
    axr(8'h08);
    chk(40'(rd[5]), 40'h1);
    erase(32'h3, 40'h0005550010);
    axw(8'h00, 32'h8);
    st_wait(1, 1'h1);
    chk({rd[4], 6'(wq.size())}, 40'h6);
    axr(8'h0C);
    chk(40'(rd[15:0]), 40'hFFFF);
    erase(32'h1, {sa, 16'h0030});
    st_wait(2, 1'h1);
    axw(8'h00, 32'h8);
    st_wait(4, 1'h1);
    chk({rd[2], wq[6][15:0]}, 40'h00B0);
    wrap_up();
  end
endmodule
`default_nettype wire
